// [rcb_regs.vh]
// Register indices, field positions, reset values and cell constants
// Assumes inclusion by bare name from every design file of the block
`ifndef RCB_REGS_VH
`define RCB_REGS_VH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define RCB_IDX_CTRL 14'h0503
`define RCB_IDX_STAT 14'h0504
`define RCB_IDX_MASK 14'h0505
`define RCB_IDX_INFO 14'h0506
// ****************************************
// Control fields
// ****************************************
`define RCB_CTRL_RST 8'h87
`define RCB_CTRL_LEVEL 7
`define RCB_CTRL_MPHY 6
`define RCB_WIDTH_HI 3
`define RCB_WIDTH_LO 2
`define RCB_SIZE_HI 1
`define RCB_SIZE_LO 0
`define RCB_WIDTH_8 2'h1
`define RCB_WIDTH_16 2'h2
`define RCB_SIZE_52 2'h0
`define RCB_SIZE_53 2'h1
`define RCB_SIZE_54 2'h2
// ****************************************
// Status and info fields
// ****************************************
`define RCB_STAT_RUNT 0
`define RCB_STAT_EMPTY 4
`define RCB_STAT_FULL 5
`define RCB_INFO_ADDR_LO 0
`define RCB_INFO_CELLS_LO 8
// ****************************************
// Cell and bus constants
// ****************************************
`define RCB_OCT_52 6'h34
`define RCB_OCT_53 6'h35
`define RCB_OCT_54 6'h36
`define RCB_FIFO_CELLS 16
`define RCB_SLOT_OCTETS 54
`define RCB_OE_8 16'h00ff
`define RCB_OE_16 16'hffff
`endif

// [rcb_cell_fifo.v]
// Cell FIFO: fixed octet slots per cell, whole-cell commit and release
// Assumes the writer never writes while full and pops only when not empty
`include "rcb_regs.vh"
module rcb_cell_fifo #(
	parameter CELLS = `RCB_FIFO_CELLS,
	parameter OCTETS = `RCB_SLOT_OCTETS,
	parameter SW = 4,
	parameter IW = 6,
	parameter AW = 10,
	parameter CW = 5
) (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire wr_en,
	input wire [IW-1:0] wr_idx,
	input wire [7:0] wr_data,
	input wire commit,
	input wire pop,
	input wire [IW-1:0] rd_idx,
	output wire [7:0] rd_hi,
	output wire [7:0] rd_lo,
	output reg [CW-1:0] cells,
	output wire full,
	output wire empty
);
	// ****************************************
	// Storage and pointers
	// ****************************************
	localparam integer CELLS_I = CELLS; // Cell count as integer
	localparam [CW-1:0] CNT_FULL = CELLS_I[CW-1:0]; // Cells when full
	localparam [SW-1:0] SLOT_LAST = CELLS_I[SW-1:0] - 1'b1; // Last slot number
	reg [7:0] mem [0:CELLS*OCTETS-1]; // Octet storage
	reg [SW-1:0] wslot_reg; // Slot being filled
	reg [SW-1:0] rslot_reg; // Slot being drained

	// Octet address of a slot and index, zero past the end
	function [AW-1:0] addr;
		input [SW-1:0] s;
		input [IW:0] i;
		reg [31:0] t;
		begin
			t = s * OCTETS + i;
			if (t >= CELLS * OCTETS) begin
				t = 32'h0;
			end
			addr = t[AW-1:0];
		end
	endfunction

	// Next slot with wrap
	function [SW-1:0] nxt;
		input [SW-1:0] s;
		begin
			nxt = (s == SLOT_LAST) ? {SW{1'b0}} : s + 1'b1;
		end
	endfunction

	assign full = (cells == CNT_FULL);
	assign empty = (cells == {CW{1'b0}});
	assign rd_hi = mem[addr(rslot_reg, {1'b0, rd_idx})];
	assign rd_lo = mem[addr(rslot_reg, {1'b0, rd_idx} + 1'b1)];

	// Octet write into the slot in progress
	always @(posedge clk) begin
		if (ce && wr_en) begin
			mem[addr(wslot_reg, {1'b0, wr_idx})] <= wr_data;
		end
	end

	// Slot pointers and cell count
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wslot_reg <= {SW{1'b0}};
			rslot_reg <= {SW{1'b0}};
			cells <= {CW{1'b0}};
		end else if (ce) begin
			if (commit && !full) begin
				wslot_reg <= nxt(wslot_reg);
			end
			if (pop && !empty) begin
				rslot_reg <= nxt(rslot_reg);
			end
			if ((commit && !full) && !(pop && !empty)) begin
				cells <= cells + 1'b1;
			end else if (!(commit && !full) && (pop && !empty)) begin
				cells <= cells - 1'b1;
			end
		end
	end
endmodule

// [rcb_top.v]
// Receive cell bus output port: cell FIFO, cell bus driver, APB registers
// Assumes clk at 20 MHz; bus clock, enable and address pins are asynchronous
// Function
// - Sixteen-cell FIFO buffers incoming cells
// - Odd parity driven alongside each word
// - Start flag high one bus period
// - Data bus released while enable high
// - Data changes only on bus clock rises
// - Eight or sixteen bit data bus
// - Cell of 52, 53 or 54 octets
// - Short cell dropped, interrupt raised
// - Empty and full visible to software
// - Cell available flag while cells wait
// - Address pins captured in multi-PHY, read back, select nothing
// - Control bit 7 stored and read back, selects nothing
// - Cell-level handshake only
// - Width field 00 off, 01 8, 10 16
// - Size field 00 52, 01 53, 10 54
//
// The implementer's own choice: the APB register port.
`include "rcb_regs.vh"
module rcb_top #(
	parameter CELLS = `RCB_FIFO_CELLS,
	parameter OCTETS = `RCB_SLOT_OCTETS
) (
	input wire clk,
	input wire sys_rst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	input wire cp_valid,
	input wire [7:0] cp_data,
	input wire cp_sop,
	input wire cp_eop,
	output reg cp_ready,
	input wire rx_cell_bus_clock,
	input wire rx_bus_output_enable_n,
	input wire [4:0] rx_phy_select_addr,
	output reg [15:0] rx_cell_data_bus,
	output reg [15:0] rx_cell_data_bus_oe,
	output reg rx_odd_parity_out,
	output reg rx_cell_start_flag,
	output reg rx_cell_available
);
	// ****************************************
	// Declarations
	// ****************************************
	reg [7:0] ctrl_reg; // Control byte
	reg runt_reg; // Sticky short cell flag
	reg mask_reg; // Interrupt mask
	reg [4:0] phy_addr_reg; // Captured address
	reg bclk_s1, bclk_s2, bclk_s3; // Bus clock sync and edge
	reg en_s1, en_s2; // Enable sync
	reg [4:0] adr_s1, adr_s2; // Address sync
	reg [5:0] wr_cnt_reg; // Octets of cell in progress
	reg skip_reg; // Dropping excess octets
	reg busy_reg; // Cell being read out
	reg [5:0] rd_idx_reg; // Next octet to present
	reg [31:0] rd_mux; // Read data selection
	reg [5:0] wr_idx_w; // Write octet index
	reg wr_en_w, commit_w, runt_w, pop_w; // Write side strobes, read side pop
	wire [4:0] cells; // Buffered cells
	wire full, empty; // FIFO state
	wire [7:0] rd_hi, rd_lo; // Octet pair at read index
	wire [5:0] size = oct_of(ctrl_reg[`RCB_SIZE_HI:`RCB_SIZE_LO]); // Octets per cell
	wire [1:0] wsel = ctrl_reg[`RCB_WIDTH_HI:`RCB_WIDTH_LO]; // Width code
	wire wide = (wsel == `RCB_WIDTH_16);
	wire active = wide || (wsel == `RCB_WIDTH_8);
	wire link_edge = bclk_s2 && !bclk_s3; // Bus clock rise seen
	wire take = link_edge && !en_s2 && active; // Reader asks for a word
	wire setup = psel && !penable; // APB setup phase
	wire xfer = psel && penable && pready; // APB completion
	wire [13:0] ridx = paddr[15:2]; // Register index
	wire hit_ctrl = (ridx == `RCB_IDX_CTRL);
	wire hit_stat = (ridx == `RCB_IDX_STAT);
	wire hit_mask = (ridx == `RCB_IDX_MASK);
	wire hit_info = (ridx == `RCB_IDX_INFO);
	wire mapped = hit_ctrl || hit_stat || hit_mask || hit_info;
	wire wr_ok = xfer && pwrite && mapped; // Register write strobe
	wire accept = cp_valid && cp_ready; // Octet taken from upstream
	wire restart = cp_sop && (wr_cnt_reg != 6'h00) && !skip_reg; // New cell mid-cell
	wire [15:0] word = wide ? {rd_hi, rd_lo} : {8'h00, rd_hi}; // Word to present

	// Octets per cell from the size code, unused code as 52
	function [5:0] oct_of;
		input [1:0] code;
		begin
			case (code)
				`RCB_SIZE_53: oct_of = `RCB_OCT_53;
				`RCB_SIZE_54: oct_of = `RCB_OCT_54;
				default: oct_of = `RCB_OCT_52;
			endcase
		end
	endfunction

	// Odd parity of a word
	function odd_par;
		input [15:0] w;
		begin
			odd_par = ~^w;
		end
	endfunction

	// ****************************************
	// Cell storage
	// ****************************************
	rcb_cell_fifo #(
		.CELLS(CELLS),
		.OCTETS(OCTETS)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.wr_en(wr_en_w),
		.wr_idx(wr_idx_w),
		.wr_data(cp_data),
		.commit(commit_w),
		.pop(pop_w),
		.rd_idx(busy_reg ? rd_idx_reg : 6'h00),
		.rd_hi(rd_hi),
		.rd_lo(rd_lo),
		.cells(cells),
		.full(full),
		.empty(empty)
	);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Two flops per pin, third flop for bus clock edge
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bclk_s1 <= 1'b0;
			bclk_s2 <= 1'b0;
			bclk_s3 <= 1'b0;
			en_s1 <= 1'b1;
			en_s2 <= 1'b1;
			adr_s1 <= 5'h00;
			adr_s2 <= 5'h00;
		end else if (ce) begin
			bclk_s1 <= rx_cell_bus_clock;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			en_s1 <= rx_bus_output_enable_n;
			en_s2 <= en_s1;
			adr_s1 <= rx_phy_select_addr;
			adr_s2 <= adr_s1;
		end
	end

	// ****************************************
	// APB slave and registers
	// ****************************************
	// Read data selection
	always @* begin
		rd_mux = 32'h0;
		if (hit_ctrl) begin
			rd_mux[7:0] = ctrl_reg;
		end
		if (hit_stat) begin
			rd_mux[`RCB_STAT_RUNT] = runt_reg;
			rd_mux[`RCB_STAT_EMPTY] = empty;
			rd_mux[`RCB_STAT_FULL] = full;
		end
		if (hit_mask) begin
			rd_mux[`RCB_STAT_RUNT] = mask_reg;
		end
		if (hit_info) begin
			rd_mux[`RCB_INFO_ADDR_LO+4:`RCB_INFO_ADDR_LO] = phy_addr_reg;
			rd_mux[`RCB_INFO_CELLS_LO+4:`RCB_INFO_CELLS_LO] = cells;
		end
	end

	// One wait-free access phase, answer latched in setup
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			if (setup) begin
				pready <= 1'b1;
				pslverr <= !mapped;
				prdata <= rd_mux;
			end else if (xfer) begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Control, mask and sticky status, set beats clear
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= `RCB_CTRL_RST;
			mask_reg <= 1'b0;
			runt_reg <= 1'b0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr_ok && hit_ctrl) begin
				ctrl_reg <= pwdata[7:0];
			end
			if (wr_ok && hit_mask) begin
				mask_reg <= pwdata[`RCB_STAT_RUNT];
			end
			if (runt_w) begin
				runt_reg <= 1'b1;
			end else if (wr_ok && hit_stat && pwdata[`RCB_STAT_RUNT]) begin
				runt_reg <= 1'b0;
			end
			irq <= (runt_reg || runt_w) && mask_reg;
		end
	end

	// ****************************************
	// Upstream write side
	// ****************************************
	// Octet placement, commit on last octet, drop on short end
	always @* begin
		wr_idx_w = restart ? 6'h00 : wr_cnt_reg;
		wr_en_w = accept && !skip_reg;
		commit_w = wr_en_w && (wr_idx_w + 6'h01 == size);
		runt_w = wr_en_w && (restart || (cp_eop && !commit_w));
	end

	// Octet counter and skip of octets past the cell size
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_cnt_reg <= 6'h00;
			skip_reg <= 1'b0;
			cp_ready <= 1'b0;
		end else if (ce) begin
			if (accept && skip_reg) begin
				skip_reg <= !cp_eop;
			end else if (commit_w) begin
				wr_cnt_reg <= 6'h00;
				skip_reg <= !cp_eop;
			end else if (wr_en_w && cp_eop) begin
				wr_cnt_reg <= 6'h00;
			end else if (wr_en_w) begin
				wr_cnt_reg <= wr_idx_w + 6'h01;
			end
			cp_ready <= !full && !(commit_w && (cells == CELLS - 1));
		end
	end

	// ****************************************
	// Cell bus read side
	// ****************************************
	// Release a finished cell at the next granted edge
	always @* begin
		pop_w = take && busy_reg && (rd_idx_reg >= size);
	end

	// Word sequencing on bus clock rises only
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			rd_idx_reg <= 6'h00;
			rx_cell_data_bus <= 16'h0000;
			rx_odd_parity_out <= 1'b1;
			rx_cell_start_flag <= 1'b0;
			rx_cell_available <= 1'b0;
			rx_cell_data_bus_oe <= 16'h0000;
			phy_addr_reg <= 5'h00;
		end else if (ce) begin
			if (!en_s2 && active) begin
				rx_cell_data_bus_oe <= wide ? `RCB_OE_16 : `RCB_OE_8;
			end else begin
				rx_cell_data_bus_oe <= 16'h0000;
			end
			if (link_edge) begin
				rx_cell_start_flag <= 1'b0;
				rx_cell_available <= active && (cells > {4'h0, busy_reg});
				if (ctrl_reg[`RCB_CTRL_MPHY]) begin
					phy_addr_reg <= adr_s2;
				end
			end
			if (take) begin
				if (busy_reg && (rd_idx_reg >= size)) begin
					busy_reg <= 1'b0;
				end else if (busy_reg || !empty) begin
					rx_cell_data_bus <= word;
					rx_odd_parity_out <= odd_par(word);
					rx_cell_start_flag <= !busy_reg;
					busy_reg <= 1'b1;
					rd_idx_reg <= (busy_reg ? rd_idx_reg : 6'h00) + (wide ? 6'h02 : 6'h01);
				end
			end
		end
	end
endmodule

// [rcb_top_chk.sv]
// Checker for the receive cell bus port, watching top ports only
// Assumes a 50 ns system clock and a bus clock of a few hundred ns
module rcb_top_chk (
	input wire clk,
	input wire sys_rst,
	input wire rx_cell_bus_clock,
	input wire rx_bus_output_enable_n,
	input wire [15:0] rx_cell_data_bus,
	input wire [15:0] rx_cell_data_bus_oe,
	input wire rx_odd_parity_out,
	input wire rx_cell_start_flag,
	input wire rx_cell_available
);
	// ********
	// Bus clock history
	// ********
	logic [3:0] bclk_hist; // Last four samples of the bus clock pin
	// Shift in the bus clock level each system cycle
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bclk_hist <= 4'h0;
		end else begin
			bclk_hist <= {bclk_hist[2:0], rx_cell_bus_clock};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	soc_one_period_a: assert property ($rose(rx_cell_start_flag) |->
		rx_cell_start_flag[*6] ##[1:4] !rx_cell_start_flag) else $error("start flag width wrong");
	odd_parity_a: assert property (rx_odd_parity_out == ~^rx_cell_data_bus) else $error("parity wrong");
	bus_released_a: assert property (rx_bus_output_enable_n[*4] |-> rx_cell_data_bus_oe == 16'h0)
		else $error("bus driven while disabled");
	lane_width_a: assert property (rx_cell_data_bus_oe inside {16'h0, 16'h00ff, 16'hffff})
		else $error("bad lane enables");
	narrow_upper_a: assert property (rx_cell_data_bus_oe == 16'h00ff |-> rx_cell_data_bus[15:8] == 8'h00)
		else $error("upper lane busy in narrow mode");
	data_on_rise_a: assert property ($changed(rx_cell_data_bus) |-> |bclk_hist)
		else $error("data changed off bus clock");
	clav_on_rise_a: assert property ($changed(rx_cell_available) |-> |bclk_hist)
		else $error("available changed off bus clock");
	soc_granted_a: assert property ($rose(rx_cell_start_flag) |-> rx_cell_data_bus_oe != 16'h0)
		else $error("start flag while bus released");
	cover property ($rose(rx_cell_start_flag));
	cover property ($fell(rx_cell_available));
	cover property ($rose(rx_cell_data_bus_oe[15]));
endmodule
bind rcb_top rcb_top_chk chk_u (.clk, .sys_rst, .rx_cell_bus_clock, .rx_bus_output_enable_n,
	.rx_cell_data_bus, .rx_cell_data_bus_oe, .rx_odd_parity_out, .rx_cell_start_flag, .rx_cell_available);

// [rcb_reader.sv]
// Cell reader model on the far side of the cell bus
// Assumes the port updates words a few system cycles after each rise
module rcb_reader (
	input wire run,
	input int nw,
	output logic bus_clk,
	output wire en_n,
	input wire [15:0] data,
	input wire [15:0] oe,
	input wire par,
	input wire soc,
	input wire clav
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] q[$]; // Words collected from each cell
	int socs = 0, perr = 0, cnt = 0, clavs = 0; // clavs: rises seen with cell available
	assign en_n = ~run;
	initial bus_clk = 1'b0;
	// Clock runs only while reading, 400 ns period
	always begin
		#200;
		bus_clk = run ? ~bus_clk : 1'b0;
	end
	// Take the words of a cell from its start flag on
	always @(posedge bus_clk) begin
		if (clav === 1'b1) clavs++;
		if (soc === 1'b1) begin
			socs++;
			cnt = nw;
		end
		if (cnt > 0) begin
			q.push_back(data & oe);
			cnt--;
			if (par !== ~^data) perr++;
		end
	end
endmodule

// [rcb_top_tb.sv]
// Bench: APB and upstream cell drivers, cell reader model
// Assumes rcb_top with its default sixteen-cell FIFO
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module rcb_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] A_CTRL = 16'h140c, A_STAT = 16'h1410, A_MASK = 16'h1414;
	localparam logic [15:0] A_INFO = 16'h1418, A_BAD = 16'h141c;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic cp_valid = 0, cp_sop = 0, cp_eop = 0, run = 0;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [7:0] cp_data = 0;
	logic [4:0] padr = 5'h0a; // Address pins
	wire [31:0] prdata;
	wire pready, pslverr, irq, cp_ready, bclk, en_n, par, soc, clav;
	wire [15:0] dbus, oe;
	int num_errors = 0, comparisons = 0, nw = 1;
	always #25 clk = ~clk;
	rcb_top dut_u (.clk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .cp_valid, .cp_data, .cp_sop, .cp_eop, .cp_ready, .rx_cell_bus_clock(bclk),
		.rx_bus_output_enable_n(en_n), .rx_phy_select_addr(padr), .rx_cell_data_bus(dbus),
		.rx_cell_data_bus_oe(oe), .rx_odd_parity_out(par), .rx_cell_start_flag(soc), .rx_cell_available(clav));
	rcb_reader rdr_u (.run, .nw, .bus_clk(bclk), .en_n, .data(dbus), .oe, .par, .soc, .clav);
	// ********
	// Tasks
	// ********
	task end_sim;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// One APB transfer, waits for pready
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin num_errors++; end_sim; end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	function logic [7:0] oct(int c, int j);
		return 8'(c * 5 + j + 1);
	endfunction
	// One cell of n octets upstream
	task send(int c, int n);
		int i, t;
		for (i = 0; i < n; i++) begin
			for (t = 0; cp_ready !== 1'b1; t++) begin
				if (t == 200) begin num_errors++; end_sim; end
				@(posedge clk);
			end
			cp_valid <= 1;
			cp_sop <= (i == 0);
			cp_eop <= (i == n - 1);
			cp_data <= oct(c, i);
			@(posedge clk);
		end
		cp_valid <= 0;
		cp_eop <= 0;
		repeat (2) @(posedge clk);
	endtask
	// Configure, load nc cells, read them back and compare
	task cells(logic [7:0] ctl, int n, int nc);
		int k, c, j;
		logic [15:0] e;
		apb(1, A_CTRL, ctl);
		for (c = 0; c < nc; c++) send(c, n);
		if (nc == 16) begin
			apb(0, A_STAT, 0);
			`CHK("full", 32'h20, rd)
			`CHK("cp_ready", 1'b0, cp_ready)
			apb(0, A_INFO, 0);
			`CHK("cells", 5'h10, rd[12:8])
		end
		nw = ctl[3] ? (n + 1) / 2 : n;
		rdr_u.q.delete();
		rdr_u.socs = 0;
		rdr_u.clavs = 0;
		run <= 1;
		for (k = 0; rdr_u.q.size() < nc * nw; k++) begin
			if (k == 20000) begin num_errors++; end_sim; end
			@(posedge clk);
		end
		repeat (40) @(posedge clk);
		run <= 0;
		for (k = 0; k < nc * nw; k++) begin
			c = k / nw;
			j = (k % nw) * (ctl[3] ? 2 : 1);
			e = ctl[3] ? {oct(c, j), oct(c, j + 1)} : {8'h00, oct(c, j)};
			`CHK("word", e, rdr_u.q[k])
		end
		`CHK("starts", nc, rdr_u.socs)
		`CHK("parity errors", 0, rdr_u.perr)
		`CHK("clav", 1'b0, clav)
		`CHK("clav rises", (nc - 1) * (nw + 1) + 1, rdr_u.clavs)
		apb(0, A_STAT, 0);
		`CHK("empty", 32'h10, rd)
	endtask
	// ********
	// Main sequence
	// ********
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		apb(0, A_CTRL, 0);
		`CHK("ctrl", 32'h87, rd)
		apb(0, A_STAT, 0);
		`CHK("stat", 32'h10, rd)
		apb(0, A_BAD, 0);
		`CHK("slverr", 1'b1, err)
		apb(1, A_MASK, 1);
		send(0, 10);
		apb(0, A_STAT, 0);
		`CHK("runt", 32'h11, rd)
		`CHK("irq", 1'b1, irq)
		apb(1, A_STAT, 1);
		apb(0, A_STAT, 0);
		`CHK("runt clr", 32'h10, rd)
		`CHK("irq clr", 1'b0, irq)
		cells(8'hc7, 52, 16);
		apb(0, A_INFO, 0);
		`CHK("addr", 5'h0a, rd[4:0])
		padr <= 5'h15;
		cells(8'hc5, 53, 1);
		cells(8'hca, 54, 2);
		padr <= 5'h03;
		cells(8'h88, 52, 1);
		apb(0, A_INFO, 0);
		`CHK("addr held", 5'h15, rd[4:0])
		apb(1, A_CTRL, 32'hc0);
		send(0, 52);
		rdr_u.socs = 0;
		run <= 1;
		repeat (40) @(posedge clk);
		`CHK("oe off", 16'h0, oe)
		`CHK("idle starts", 0, rdr_u.socs)
		`CHK("idle clav", 1'b0, clav)
		run <= 0;
		end_sim;
	end
endmodule
